// ==== mprm_pkg.sv ====
// Package for the module power and reset manager: states, timing, grouped signals.
package mprm_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_PS   = 8000;
    localparam int unsigned PRESS_MIN_MS    = 16;
    // Cycles per millisecond first, so the product stays inside 32 bits
    localparam int unsigned PRESS_CYCLES    = PRESS_MIN_MS * ((1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int unsigned RESET_HOLD_US   = 1;
    localparam int unsigned RESET_CYCLES    = (RESET_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WARN_LEAD_US    = 1;
    localparam int unsigned WARN_CYCLES     = (WARN_LEAD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned NUM_BTN         = 4;

    // Button indices in the qualified-press vector
    localparam int unsigned BTN_POWER = 0;
    localparam int unsigned BTN_RESET = 1;
    localparam int unsigned BTN_LID   = 2;
    localparam int unsigned BTN_SLEEP = 3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_WAIT_OK = 3'b001,
        ST_RUN     = 3'b010,
        ST_WARN    = 3'b011,
        ST_SUSPEND = 3'b100
    } mprm_state_e;

    // Raw pin levels from the carrier, all asynchronous
    typedef struct packed {
        logic powerButtonN;
        logic resetButtonN;
        logic lidN;
        logic sleepN;
        logic supplyGood;
        logic mainSupply12vOk;
        logic pcieWakeN;
        logic batteryLowN;
    } mprm_pins_s;

    // Requests from module software and chipset logic, same clock
    typedef struct packed {
        logic softResetReq;
        logic watchdogTimeout;
        logic suspendReq;
        logic softOffReq;
    } mprm_sw_s;

    // One-cycle event reports and the lid level towards the system
    typedef struct packed {
        logic powerButtonEvent;
        logic sleepButtonEvent;
        logic lidChangeEvent;
        logic wakeEvent;
        logic powerFail;
        logic lidClosed;
    } mprm_evt_s;

endpackage : mprm_pkg

// ==== mprm_power_reset_manager.sv ====
// Power, reset and suspend-state sequencing between processor module and carrier.
`timescale 1ns/1ps

module mprm_power_reset_manager (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire mprm_pkg::mprm_pins_s pins,
    input  wire mprm_pkg::mprm_sw_s   sw,
    input  wire logic                 espiMode,
    output logic                      carrier_reset_n,
    output logic                      suspend_ram_n,
    output logic                      suspend_disk_n,
    output logic                      soft_off_n,
    output logic                      suspend_warning_n,
    output logic                      watchdog_expired_out,
    output mprm_pkg::mprm_evt_s       events
);
    import mprm_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int unsigned NSYNC = $bits(mprm_pins_s) + 1;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    mprm_pins_s       pinS;
    logic             espiS;

    // Two stages; only syncB is read downstream
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= '1;
            syncB <= '1;
        end else begin
            syncA <= {pins, espiMode};
            syncB <= syncA;
        end
    end
    assign pinS  = mprm_pins_s'(syncB[NSYNC-1:1]);
    assign espiS = syncB[0];

    // ****************************************************************
    // Press qualification
    // ****************************************************************
    logic [NUM_BTN-1:0] btnLevelN;
    logic [NUM_BTN-1:0] btnPress;    // One-cycle: press qualified
    logic [NUM_BTN-1:0] btnRelease;  // One-cycle: release after qualified press

    assign btnLevelN = {pinS.sleepN, pinS.lidN, pinS.resetButtonN, pinS.powerButtonN};

    // Low time counted per button; a press counts once when it reaches the
    // minimum width, so a held button never repeats
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BTN; gi++) begin : g_btn
            logic [CNT_W-1:0] lowCnt;
            logic             held;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lowCnt         <= '0;
                    held           <= 1'b0;
                    btnPress[gi]   <= 1'b0;
                    btnRelease[gi] <= 1'b0;
                end else begin
                    btnPress[gi]   <= 1'b0;
                    btnRelease[gi] <= 1'b0;
                    if (btnLevelN[gi]) begin
                        lowCnt         <= '0;
                        held           <= 1'b0;
                        btnRelease[gi] <= held;
                    end else if (!held) begin
                        if (lowCnt == CNT_W'(PRESS_CYCLES - 1)) begin
                            held         <= 1'b1;
                            btnPress[gi] <= 1'b1;
                        end else begin
                            lowCnt <= lowCnt + CNT_W'(1);
                        end
                    end
                end
            end
        end
    endgenerate

    // Wake and power-fail edges on the synchronised levels
    logic wakePrevN;
    logic batPrevN;
    logic wakeEdge;
    logic batEdge;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakePrevN <= 1'b1;
            batPrevN  <= 1'b1;
        end else begin
            wakePrevN <= pinS.pcieWakeN;
            batPrevN  <= pinS.batteryLowN;
        end
    end
    assign wakeEdge = wakePrevN && !pinS.pcieWakeN;
    assign batEdge  = batPrevN && !pinS.batteryLowN;

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    mprm_state_e      state;
    mprm_state_e      next_state;
    logic [CNT_W-1:0] warnCnt;
    logic             wakeReq;

    assign wakeReq = btnPress[BTN_POWER] || btnPress[BTN_SLEEP] || wakeEdge;

    // Next-state choice; power-good gates every path into running
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (wakeReq) begin
                    next_state = ST_WAIT_OK;
                end
            end
            ST_WAIT_OK: begin
                if (pinS.supplyGood && pinS.mainSupply12vOk) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (btnPress[BTN_POWER] || sw.softOffReq || !pinS.batteryLowN) begin
                    next_state = ST_OFF;
                end else if (sw.suspendReq || btnPress[BTN_SLEEP]) begin
                    next_state = ST_WARN;
                end
            end
            ST_WARN: begin
                if (warnCnt == CNT_W'(WARN_CYCLES - 1)) begin
                    next_state = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (!pinS.batteryLowN) begin
                    next_state = ST_OFF;
                end else if (wakeReq) begin
                    next_state = ST_WAIT_OK;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // State register; the board starts in soft-off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Lead time between warning and suspend entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warnCnt <= '0;
        end else if (state == ST_WARN) begin
            warnCnt <= warnCnt + CNT_W'(1);
        end else begin
            warnCnt <= '0;
        end
    end

    // ****************************************************************
    // Carrier reset
    // ****************************************************************
    logic             resetCause;
    logic [CNT_W-1:0] rstCnt;

    // Button acts once per qualified press, so holding it low only yields
    // one fixed-length pulse rather than a stuck reset
    assign resetCause = btnPress[BTN_RESET] || sw.watchdogTimeout || sw.softResetReq;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstCnt <= '0;
        end else if (resetCause) begin
            rstCnt <= CNT_W'(RESET_CYCLES);
        end else if (rstCnt != '0) begin
            rstCnt <= rstCnt - CNT_W'(1);
        end
    end

    // Supply faults hold reset for as long as they last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_reset_n <= 1'b0;
        end else begin
            carrier_reset_n <= !(resetCause || rstCnt != '0 || !pinS.supplyGood
                                 || !pinS.mainSupply12vOk || state == ST_OFF
                                 || state == ST_WAIT_OK || state == ST_SUSPEND);
        end
    end

    // ****************************************************************
    // State outputs
    // ****************************************************************
    // Report-only outputs registered from the next-state decode; the warning is masked in eSPI mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            suspend_ram_n     <= 1'b1;
            suspend_disk_n    <= 1'b0;
            soft_off_n        <= 1'b0;
            suspend_warning_n <= 1'b1;
        end else begin
            suspend_ram_n     <= !(next_state == ST_SUSPEND || next_state == ST_OFF);
            suspend_disk_n    <= !(next_state == ST_OFF);
            soft_off_n        <= !(next_state == ST_OFF);
            suspend_warning_n <= !(!espiS && (next_state == ST_WARN || next_state == ST_SUSPEND));
        end
    end

    // Watchdog flag stays set until the next run state begins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_expired_out <= 1'b0;
        end else if (sw.watchdogTimeout) begin
            watchdog_expired_out <= 1'b1;
        end else if (state == ST_WAIT_OK && next_state == ST_RUN) begin
            watchdog_expired_out <= 1'b0;
        end
    end

    // Event pulses and lid level for the operating system
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            events <= '0;
        end else begin
            events.powerButtonEvent <= btnPress[BTN_POWER];
            events.sleepButtonEvent <= btnPress[BTN_SLEEP];
            events.lidChangeEvent   <= btnPress[BTN_LID] || btnRelease[BTN_LID];
            events.wakeEvent        <= wakeEdge;
            events.powerFail        <= batEdge;
            events.lidClosed        <= !pinS.lidN;
        end
    end

endmodule : mprm_power_reset_manager

// ==== mprm_chk.sv ====
// Port-level assertions for the power and reset manager.
`timescale 1ns/1ps
module mprm_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire mprm_pkg::mprm_pins_s pins,
    input wire mprm_pkg::mprm_sw_s   sw,
    input wire logic                 espiMode,
    input wire logic                 carrier_reset_n,
    input wire logic                 suspend_ram_n,
    input wire logic                 suspend_disk_n,
    input wire logic                 soft_off_n,
    input wire logic                 suspend_warning_n,
    input wire logic                 watchdog_expired_out,
    input wire mprm_pkg::mprm_evt_s  events
);
    import mprm_pkg::*;
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wdog_reset_a: assert property (sw.watchdogTimeout |=> !carrier_reset_n)
        else $error("carrier reset missed watchdog");
    soft_reset_a: assert property (sw.softResetReq |=> !carrier_reset_n [*8])
        else $error("software reset pulse too short");
    // Sync stages take two edges, the output one more
    supply_reset_a: assert property (!pins.supplyGood [*4] |-> !carrier_reset_n)
        else $error("carrier reset high with bad supply");
    tied_off_a: assert property (soft_off_n == suspend_disk_n)
        else $error("soft-off and disk outputs differ");
    wdog_out_a: assert property (sw.watchdogTimeout |=> watchdog_expired_out)
        else $error("watchdog output not set");
    wake_evt_a: assert property ($fell(pins.pcieWakeN) && !suspend_ram_n |-> ##[2:5] events.wakeEvent)
        else $error("wake event missing");
    batt_evt_a: assert property ($fell(pins.batteryLowN) |-> ##[2:5] events.powerFail)
        else $error("power-fail event missing");
    sync_depth_a: assert property ($fell(pins.batteryLowN) |=> !events.powerFail [*2])
        else $error("battery edge seen before two sync stages");
    warn_lead_a: assert property ($fell(suspend_ram_n) && soft_off_n && !espiMode |-> !$past(suspend_warning_n))
        else $error("suspend entered without warning");
    warn_len_a: assert property ($fell(suspend_warning_n) |=> suspend_ram_n [*8])
        else $error("warning lead too short");
    cover property ($fell(suspend_ram_n) && soft_off_n);
    cover property (events.wakeEvent);
    cover property ($rose(watchdog_expired_out));
endmodule : mprm_chk

bind mprm_power_reset_manager mprm_chk chk (.clk(clk), .rst_n(rst_n), .pins(pins), .sw(sw),
    .espiMode(espiMode), .carrier_reset_n(carrier_reset_n), .suspend_ram_n(suspend_ram_n),
    .suspend_disk_n(suspend_disk_n), .soft_off_n(soft_off_n), .suspend_warning_n(suspend_warning_n),
    .watchdog_expired_out(watchdog_expired_out), .events(events));

// ==== mprm_carrier_model.sv ====
// Carrier-side model: slow supply, wake source, battery and idle buttons.
`timescale 1ns/1ps
module mprm_carrier_model (
    input  wire logic            clk,
    input  wire logic            supplyOn,
    input  wire logic            wakeReq,
    input  wire logic            battery_low_n,
    input  wire logic [3:0]      buttonsN,
    output mprm_pkg::mprm_pins_s pins
);
    import mprm_pkg::*;
    int unsigned rampCnt = 0;
    int unsigned wakeCnt = 0;
    logic        supplyS = 1'b0;
    logic        wakeS = 1'b0;
    // Requests taken on the rising edge, so falling-edge bench writes never race
    always @(posedge clk) begin
        supplyS <= supplyOn;
        wakeS   <= wakeReq;
    end
    // Supply good only 40 cycles after switch-on, so startup must wait
    always @(negedge clk) begin
        rampCnt <= supplyS ? ((rampCnt < 40) ? rampCnt + 1 : rampCnt) : 0;
        wakeCnt <= wakeS ? 8 : ((wakeCnt != 0) ? wakeCnt - 1 : 0);
    end
    // Buttons rest high; a full 16 ms press outlasts the run, so only short glitches are made
    assign pins = {buttonsN, rampCnt == 40, rampCnt == 40, wakeCnt == 0, !battery_low_n};
endmodule : mprm_carrier_model

// ==== mprm_power_reset_manager_bench.sv ====
// Self-checking bench for the power and reset manager.
`timescale 1ns/1ps
module mprm_power_reset_manager_bench;
    import mprm_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       supplyOn = 1'b0;
    logic       wakeReq = 1'b0;
    logic       battery_low_n = 1'b0;
    logic       espiMode = 1'b0;
    logic [3:0] btnN = 4'hF;
    int         btnSeen = 0;
    mprm_sw_s   sw = '0;
    mprm_pins_s pins;
    mprm_evt_s  events;
    logic       carrier_reset_n, suspend_ram_n, suspend_disk_n, soft_off_n, suspend_warning_n, watchdog_expired_out;
    int         err_total = 0;
    int         n_checks = 0;
    int         wakeSeen = 0;
    int         failSeen = 0;
    int         n;
    mprm_power_reset_manager dut (.clk(clk), .rst_n(rst_n), .pins(pins), .sw(sw), .espiMode(espiMode),
        .carrier_reset_n(carrier_reset_n), .suspend_ram_n(suspend_ram_n), .suspend_disk_n(suspend_disk_n),
        .soft_off_n(soft_off_n), .suspend_warning_n(suspend_warning_n),
        .watchdog_expired_out(watchdog_expired_out), .events(events));
    mprm_carrier_model carrier (.clk(clk), .supplyOn(supplyOn), .wakeReq(wakeReq), .battery_low_n(battery_low_n),
        .buttonsN(btnN), .pins(pins));
    // ****************************************
    // Helpers
    // ****************************************
    initial forever #4 clk = ~clk;
    // Event pulses last one cycle; counted mid-cycle where they are settled
    always @(negedge clk) begin
        if (events.wakeEvent === 1'b1) wakeSeen++;
        if (events.powerFail === 1'b1) failSeen++;
        if ({events.powerButtonEvent, events.sleepButtonEvent, events.lidChangeEvent} !== 3'b000) btnSeen++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Wait for {reset, ram, off, warning}; the bound cuts a hang short
    task automatic waitFor(input logic [3:0] exp);
        n = 0;
        while ({carrier_reset_n, suspend_ram_n, soft_off_n, suspend_warning_n} !== exp) begin
            @(negedge clk);
            n++;
            if (n > 5000) begin
                check(8'h00, 8'hFF);
                finish_test();
            end
        end
    endtask : waitFor
    task automatic wakeUp();
        wakeReq = 1'b1;
        @(negedge clk) wakeReq = 1'b0;
        waitFor(4'b0111);
        waitFor(4'b1111);
    endtask : wakeUp
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic bootT();
        waitFor(4'b0001);
        wakeUp();
        check(n >= 30, 1'b1);
        check(wakeSeen[7:0], 8'h01);
    endtask : bootT
    task automatic suspendT();
        sw.suspendReq = 1'b1;
        @(negedge clk) sw.suspendReq = 1'b0;
        waitFor(4'b1110);
        waitFor(4'b0010);
        check(n >= WARN_CYCLES - 2, 1'b1);
        check(suspend_disk_n, 1'b1);
        wakeUp();
    endtask : suspendT
    task automatic wdogT();
        sw.watchdogTimeout = 1'b1;
        @(negedge clk) sw.watchdogTimeout = 1'b0;
        check(carrier_reset_n, 1'b0);
        waitFor(4'b1111);
        check(n >= RESET_CYCLES - 2, 1'b1);
        check(watchdog_expired_out, 1'b1);
        sw.softOffReq = 1'b1;
        @(negedge clk) sw.softOffReq = 1'b0;
        waitFor(4'b0001);
        wakeUp();
        check(watchdog_expired_out, 1'b0);
    endtask : wdogT
    task automatic supplyT();
        supplyOn = 1'b0;
        repeat (6) @(negedge clk);
        check(carrier_reset_n, 1'b0);
        supplyOn = 1'b1;
        waitFor(4'b1111);
        sw.softResetReq = 1'b1;
        @(negedge clk) sw.softResetReq = 1'b0;
        check(carrier_reset_n, 1'b0);
        waitFor(4'b1111);
        check(n >= RESET_CYCLES - 2, 1'b1);
    endtask : supplyT
    task automatic battT();
        battery_low_n = 1'b1;
        waitFor(4'b0001);
        repeat (6) @(negedge clk);
        check(failSeen[7:0], 8'h01);
        battery_low_n = 1'b0;
    endtask : battT
    // Presses far below the minimum width leave state and event pulses alone; only the lid level follows the pin
    task automatic glitchT();
        btnN = 4'h7;
        repeat (200) @(negedge clk);
        btnN = 4'hF;
        repeat (10) @(negedge clk);
        check({carrier_reset_n, suspend_ram_n, soft_off_n, suspend_warning_n}, 4'b0001);
        wakeUp();
        btnN = 4'hB;
        repeat (200) @(negedge clk);
        check(carrier_reset_n, 1'b1);
        btnN = 4'hD;
        repeat (10) @(negedge clk);
        check(carrier_reset_n, 1'b1);
        check(events.lidClosed, 1'b1);
        repeat (190) @(negedge clk);
        btnN = 4'hE;
        repeat (200) @(negedge clk);
        btnN = 4'hF;
        repeat (10) @(negedge clk);
        check({carrier_reset_n, suspend_ram_n, soft_off_n, suspend_warning_n}, 4'b1111);
        check(events.lidClosed, 1'b0);
        check(btnSeen[7:0], 8'h00);
    endtask : glitchT
    // In eSPI mode the warning output stays quiet through the lead time
    task automatic espiT();
        espiMode = 1'b1;
        repeat (4) @(negedge clk);
        sw.suspendReq = 1'b1;
        @(negedge clk) sw.suspendReq = 1'b0;
        repeat (20) @(negedge clk);
        check(suspend_warning_n, 1'b1);
        waitFor(4'b0011);
        check(n >= WARN_CYCLES - 30, 1'b1);
        wakeUp();
        espiMode = 1'b0;
    endtask : espiT
    initial begin
        supplyOn = 1'b1;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        bootT();
        suspendT();
        wdogT();
        supplyT();
        battT();
        glitchT();
        espiT();
        finish_test();
    end
endmodule : mprm_power_reset_manager_bench
